//--- mil_pkg.sv
// Constants, register map and state type shared by the interrupt logic files.
package mil_pkg;

    // ==========================================================
    // Bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFF_INTCTL = 8'h00;
    localparam logic [7:0] OFF_OPTION = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;

    // ==========================================================
    // Field positions of interrupt_control
    localparam int B_GIE       = 7;
    localparam int B_TMR_EN    = 5;
    localparam int B_PIN_EN    = 4;
    localparam int B_PORT_EN   = 3;
    localparam int B_TMR_FLAG  = 2;
    localparam int B_PIN_FLAG  = 1;
    localparam int B_PORT_FLAG = 0;

    // Field position of the edge select in the option register.
    localparam int B_EDGE_SEL = 6;

    // Field positions of the read-only status register.
    localparam int S_REQ   = 0;
    localparam int S_SLEEP = 1;
    localparam int S_BUSY  = 2;

    // ==========================================================
    // Reset values
    localparam logic [7:0] INTCTL_RST = 8'h00;
    localparam logic [7:0] OPTION_RST = 8'hff;

    // ==========================================================
    // Core side constants
    localparam int         PC_W   = 13;
    localparam logic [12:0] VECTOR = 13'h0004;
    localparam logic [7:0] TMR_MAX  = 8'hff;
    localparam logic [7:0] TMR_ZERO = 8'h00;

    // Instruction cycle phases, one pclk each.
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q4 = 2'h3;

    // Interrupt blocking after a software clear of the global enable.
    localparam logic [1:0] BLK_START = 2'h2;
    localparam logic [1:0] BLK_NOP   = 2'h1;
    localparam logic [1:0] BLK_NONE  = 2'h0;

    // Settling count for the port compare latch after reset.
    localparam logic [1:0] SETTLE_DONE = 2'h3;

    // ==========================================================
    // Entry sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_DUMMY1, ST_DUMMY2} mil_state_t;

endpackage

//--- mil_evt_if.sv
// Interface carrying source events between the pin front end and the core logic.
`timescale 1ns/1ps
interface mil_evt_if;
    logic pin_evt;      // Selected edge seen on the external pin.
    logic tmr_evt;      // Timer rolled over.
    logic port_evt;     // Monitored port bits differ from last read.
    logic pin_edge_sel; // High selects the rising edge.
    logic port_read;    // Core reads the port this cycle.

    modport src (
        output pin_evt,
        output tmr_evt,
        output port_evt,
        input  pin_edge_sel,
        input  port_read
    );

    modport sink (
        input  pin_evt,
        input  tmr_evt,
        input  port_evt,
        output pin_edge_sel,
        output port_read
    );
endinterface

//--- mil_src.sv
// Source front end: pin synchronisers, edge, rollover and port change detection.
`timescale 1ns/1ps
module mil_src #(
    parameter int PORT_W = 4
) (
    input  wire logic              pclk,        // System clock.
    input  wire logic              presetn,     // Asynchronous reset, active low.
    input  wire logic              ext_pin,     // External interrupt pin.
    input  wire logic [PORT_W-1:0] port_pins,   // Monitored upper port pins.
    input  wire logic [7:0]        timer_count, // Timer register value.
    mil_evt_if.src                 evt          // Events towards the core logic.
);

    // ==========================================================
    // Synchronisers and history
    logic              pin_s1_q;
    logic              pin_s2_q;
    logic              pin_prev_q;
    logic [PORT_W-1:0] port_s1_q;
    logic [PORT_W-1:0] port_s2_q;
    logic [PORT_W-1:0] port_latch_q;
    logic [7:0]        tmr_prev_q;
    logic [1:0]        settle_q;
    logic              settled;

    assign settled = (settle_q == mil_pkg::SETTLE_DONE);

    // Two flops on every pin before anything looks at it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q  <= 1'b0;
            pin_s2_q  <= 1'b0;
            port_s1_q <= '0;
            port_s2_q <= '0;
        end else begin
            pin_s1_q  <= ext_pin;
            pin_s2_q  <= pin_s1_q;
            port_s1_q <= port_pins;
            port_s2_q <= port_s1_q;
        end
    end

    // History of pin and timer, and the port value seen at the last read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev_q   <= 1'b0;
            tmr_prev_q   <= mil_pkg::TMR_ZERO;
            port_latch_q <= '0;
            settle_q     <= 2'h0;
        end else begin
            pin_prev_q <= pin_s2_q;
            tmr_prev_q <= timer_count;
            if (!settled) begin
                settle_q <= settle_q + 2'h1;
            end
            // The latch follows the pins until the synchronisers have settled.
            if (!settled || evt.port_read) begin
                port_latch_q <= port_s2_q;
            end
        end
    end

    // Event decode; a read racing a pin change may still flag it.
    assign evt.pin_evt = settled && (evt.pin_edge_sel ? (pin_s2_q && !pin_prev_q)
                                                      : (!pin_s2_q && pin_prev_q));
    assign evt.tmr_evt = (tmr_prev_q == mil_pkg::TMR_MAX)
                      && (timer_count == mil_pkg::TMR_ZERO);
    assign evt.port_evt = settled && (port_s2_q != port_latch_q);

    // ==========================================================
    // Checks
    a_edge_dir: assert property (@(posedge pclk) disable iff (!presetn)
        evt.pin_evt |-> (pin_s2_q == evt.pin_edge_sel))
        else $error("Pin event on the wrong edge.");

    a_tmr_roll: assert property (@(posedge pclk) disable iff (!presetn)
        evt.tmr_evt |-> ($past(timer_count) == mil_pkg::TMR_MAX))
        else $error("Timer event without rollover.");

endmodule

//--- mil_top.sv
// Interrupt logic top: flags, enables, APB registers, entry sequencer and sleep wake.
// Notes on behaviour
// - three sources: pin edge, timer, port change.
// - global enable passes unmasked requests, else blocks.
// - reset clears the global enable.
// - return from interrupt sets global enable again.
// - entry clears enable, pushes PC, loads 0004h.
// - external events serviced three to four cycles later.
// - latency independent of instruction length.
// - flags set regardless of any enable.
// - enable clear forces one NOP, requests wait.
// - pin edge polarity chosen by option bit 6.
// - selected pin edge sets pin flag.
// - pin enable clear disables pin interrupt.
// - enabled pin interrupt wakes from sleep.
// - timer rollover sets timer overflow flag.
// - timer enable gates timer overflow interrupt.
// - port bits change sets port flag, own enable.
// - change during port read may set flag.
// - pin flag sets only in Q4 or Q1.
// - only the return PC is saved.
// - enabled interrupt wakes; enable clear continues inline.
// - pending enabled flag makes sleep wake at once.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module mil_top (
    input  wire logic        pclk,             // System clock, one pclk per Q phase.
    input  wire logic        presetn,          // Asynchronous reset, active low.
    input  wire logic        psel,             // APB select.
    input  wire logic        penable,          // APB enable.
    input  wire logic        pwrite,           // APB direction, high writes.
    input  wire logic [7:0]  paddr,            // APB byte address.
    input  wire logic [31:0] pwdata,           // APB write data.
    output logic      [31:0] prdata,           // APB read data.
    output logic             pready,           // APB ready.
    output logic             pslverr,          // APB error on unmapped address.
    input  wire logic        external_irq_pin, // External interrupt pin.
    input  wire logic [3:0]  port_two_hi,      // Upper four port pins.
    input  wire logic [7:0]  timer_count,      // Timer register value.
    input  wire logic        core_port_read,   // Core reads the port, one cycle.
    input  wire logic        core_return_from_irq_instr,      // Return from interrupt executed, one cycle.
    input  wire logic        core_sleep,       // Sleep instruction executed, one cycle.
    output logic             core_irq_req,     // Enabled request to the core.
    output logic             core_irq_entry,   // Push PC and load vector, one cycle.
    output logic      [12:0] core_vector_addr, // Vector address.
    output logic             core_nop,         // Core executes a dummy cycle.
    output logic             core_asleep,      // Core held in sleep.
    output logic             core_wake,        // Wake from sleep, one cycle.
    output logic      [1:0]  core_phase        // Current Q phase.
);

    // ==========================================================
    // Source front end
    mil_evt_if evt ();

    mil_src #(
        .PORT_W (4)
    ) u_src (
        .pclk        (pclk),
        .presetn     (presetn),
        .ext_pin     (external_irq_pin),
        .port_pins   (port_two_hi),
        .timer_count (timer_count),
        .evt         (evt)
    );

    // ==========================================================
    // State
    logic                 gie_q;
    logic                 gie_d;
    logic                 tmr_en_q;
    logic                 pin_en_q;
    logic                 port_en_q;
    logic                 tmr_flag_q;
    logic                 tmr_flag_d;
    logic                 pin_flag_q;
    logic                 pin_flag_d;
    logic                 port_flag_q;
    logic                 port_flag_d;
    logic                 pin_pend_q;
    logic                 pin_pend_d;
    logic [7:0]           option_q;
    logic [1:0]           phase_q;
    logic [1:0]           blk_q;
    logic [1:0]           blk_d;
    logic                 asleep_q;
    logic                 asleep_d;
    logic                 wake_q;
    logic                 nop_q;
    logic                 irq_req_q;
    logic                 take_q;
    logic [12:0]          vec_q;
    logic [31:0]          prdata_q;
    logic                 pready_q;
    logic                 pslverr_q;
    mil_pkg::mil_state_t  state_q;
    mil_pkg::mil_state_t  state_d;
    logic                 take;

    // Address match used by every register decode.
    function automatic logic mil_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ==========================================================
    // APB decode
    logic        setup;
    logic        access;
    logic        mapped;
    logic        wr_intctl;
    logic        wr_option;
    logic        gie_clr_wr;
    logic [7:0]  intctl_rd;
    logic [7:0]  status_rd;
    logic [31:0] rdata;

    // Setup answers one cycle later; the write lands at the access edge.
    assign setup      = psel && !penable;
    assign access     = psel && penable && pready_q;
    assign mapped     = mil_hit(paddr, mil_pkg::OFF_INTCTL)
                     || mil_hit(paddr, mil_pkg::OFF_OPTION)
                     || mil_hit(paddr, mil_pkg::OFF_STATUS);
    assign wr_intctl  = access && pwrite && mil_hit(paddr, mil_pkg::OFF_INTCTL);
    assign wr_option  = access && pwrite && mil_hit(paddr, mil_pkg::OFF_OPTION);
    assign gie_clr_wr = wr_intctl && gie_q && !pwdata[mil_pkg::B_GIE];

    // Read views; bit 6 of interrupt_control is reserved and reads zero.
    assign intctl_rd = {gie_q, 1'b0, tmr_en_q, pin_en_q, port_en_q,
                        tmr_flag_q, pin_flag_q, port_flag_q};
    assign status_rd = {5'h00, (state_q != mil_pkg::ST_IDLE), asleep_q, irq_req_q};
    assign rdata = mil_hit(paddr, mil_pkg::OFF_INTCTL) ? {24'h000000, intctl_rd} :
                   mil_hit(paddr, mil_pkg::OFF_OPTION) ? {24'h000000, option_q}  :
                   mil_hit(paddr, mil_pkg::OFF_STATUS) ? {24'h000000, status_rd} :
                   32'h00000000;

    // APB answer registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
            if (setup) begin
                prdata_q <= pwrite ? 32'h00000000 : rdata;
            end
        end
    end

    // ==========================================================
    // Instruction cycle phase counter
    logic q4_end;
    logic pin_window;

    assign q4_end     = (phase_q == mil_pkg::PH_Q4);
    assign pin_window = (phase_q == mil_pkg::PH_Q4) || (phase_q == mil_pkg::PH_Q1);

    // The phase runs Q1 to Q4 and wraps; latency counts on it alone.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= mil_pkg::PH_Q1;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // ==========================================================
    // Flags: a hardware set always beats a software clear in the same cycle
    logic pend_tmr;
    logic pend_pin;
    logic pend_port;
    logic pending;
    logic irq_req;

    assign pin_pend_d  = evt.pin_evt || (pin_pend_q && !pin_window);
    assign pin_flag_d  = (pin_pend_q && pin_window)
                      || (wr_intctl ? pwdata[mil_pkg::B_PIN_FLAG] : pin_flag_q);
    assign tmr_flag_d  = evt.tmr_evt
                      || (wr_intctl ? pwdata[mil_pkg::B_TMR_FLAG] : tmr_flag_q);
    assign port_flag_d = evt.port_evt
                      || (wr_intctl ? pwdata[mil_pkg::B_PORT_FLAG] : port_flag_q);

    // Each source is gated by its own enable, then by the global enable.
    assign pend_tmr  = tmr_flag_q && tmr_en_q;
    assign pend_pin  = pin_flag_q && pin_en_q;
    assign pend_port = port_flag_q && port_en_q;
    assign pending   = pend_tmr || pend_pin || pend_port;
    assign irq_req   = gie_q && pending;

    // Flag registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_flag_q  <= mil_pkg::INTCTL_RST[mil_pkg::B_TMR_FLAG];
            pin_flag_q  <= mil_pkg::INTCTL_RST[mil_pkg::B_PIN_FLAG];
            port_flag_q <= mil_pkg::INTCTL_RST[mil_pkg::B_PORT_FLAG];
            pin_pend_q  <= 1'b0;
        end else begin
            tmr_flag_q  <= tmr_flag_d;
            pin_flag_q  <= pin_flag_d;
            port_flag_q <= port_flag_d;
            pin_pend_q  <= pin_pend_d;
        end
    end

    // ==========================================================
    // Enables and option register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_en_q  <= mil_pkg::INTCTL_RST[mil_pkg::B_TMR_EN];
            pin_en_q  <= mil_pkg::INTCTL_RST[mil_pkg::B_PIN_EN];
            port_en_q <= mil_pkg::INTCTL_RST[mil_pkg::B_PORT_EN];
            option_q  <= mil_pkg::OPTION_RST;
        end else begin
            if (wr_intctl) begin
                tmr_en_q  <= pwdata[mil_pkg::B_TMR_EN];
                pin_en_q  <= pwdata[mil_pkg::B_PIN_EN];
                port_en_q <= pwdata[mil_pkg::B_PORT_EN];
            end
            if (wr_option) begin
                option_q <= pwdata[7:0];
            end
        end
    end

    assign evt.pin_edge_sel = option_q[mil_pkg::B_EDGE_SEL];
    assign evt.port_read    = core_port_read;

    // ==========================================================
    // Global enable: entry clears it, return sets it, software writes it
    always_comb begin
        gie_d = gie_q;
        if (wr_intctl) begin
            gie_d = pwdata[mil_pkg::B_GIE];
        end
        if (core_return_from_irq_instr) begin
            gie_d = 1'b1;
        end
        if (take) begin
            gie_d = 1'b0;
        end
    end

    // A software clear blocks the rest of this cycle and all of the next.
    assign blk_d = gie_clr_wr ? mil_pkg::BLK_START :
                   (q4_end && (blk_q != mil_pkg::BLK_NONE)) ? blk_q - 2'h1 : blk_q;

    // ==========================================================
    // Entry sequencer: two dummy cycles, then the vector load
    always_comb begin
        state_d = state_q;
        take    = 1'b0;
        case (state_q)
            mil_pkg::ST_IDLE: begin
                if (q4_end && irq_req && !asleep_q && (blk_q == mil_pkg::BLK_NONE)) begin
                    state_d = mil_pkg::ST_DUMMY1;
                end
            end
            mil_pkg::ST_DUMMY1: begin
                if (blk_q != mil_pkg::BLK_NONE || gie_clr_wr) begin
                    state_d = mil_pkg::ST_IDLE;
                end else if (q4_end) begin
                    state_d = mil_pkg::ST_DUMMY2;
                end
            end
            mil_pkg::ST_DUMMY2: begin
                // A clear landing on the vector edge itself must also stop the entry.
                if (blk_q != mil_pkg::BLK_NONE || gie_clr_wr) begin
                    state_d = mil_pkg::ST_IDLE;
                end else if (q4_end) begin
                    state_d = mil_pkg::ST_IDLE;
                    take    = 1'b1;
                end
            end
            default: begin
                state_d = mil_pkg::ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Sleep: any enabled pending flag wakes, whatever the global enable
    logic wake_now;

    assign wake_now = asleep_q && pending && !core_sleep;
    assign asleep_d = core_sleep ? 1'b1 : (wake_now ? 1'b0 : asleep_q);

    // Control registers of the sequencer and sleep logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie_q    <= mil_pkg::INTCTL_RST[mil_pkg::B_GIE];
            blk_q    <= mil_pkg::BLK_NONE;
            state_q  <= mil_pkg::ST_IDLE;
            asleep_q <= 1'b0;
        end else begin
            gie_q    <= gie_d;
            blk_q    <= blk_d;
            state_q  <= state_d;
            asleep_q <= asleep_d;
        end
    end

    // Core facing outputs, all registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_q    <= 1'b0;
            nop_q     <= 1'b0;
            irq_req_q <= 1'b0;
            take_q    <= 1'b0;
            vec_q     <= mil_pkg::VECTOR;
        end else begin
            wake_q    <= wake_now;
            nop_q     <= (state_d != mil_pkg::ST_IDLE) || (blk_d == mil_pkg::BLK_NOP);
            irq_req_q <= irq_req;
            take_q    <= take;
            vec_q     <= mil_pkg::VECTOR;
        end
    end

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign core_irq_req     = irq_req_q;
    assign core_irq_entry   = take_q;
    assign core_vector_addr = vec_q;
    assign core_nop         = nop_q;
    assign core_asleep      = asleep_q;
    assign core_wake        = wake_q;
    assign core_phase       = phase_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_go;
        (state_q == mil_pkg::ST_IDLE) && (state_d == mil_pkg::ST_DUMMY1);
    endsequence

    sequence s_quiet;
        (blk_q == mil_pkg::BLK_NONE && !gie_clr_wr) [*8];
    endsequence

    a_entry_latency: assert property (s_go ##1 s_quiet |=> core_irq_entry)
        else $error("Vector not loaded nine cycles after decision.");

    a_entry_fixed: assert property (s_go |-> !core_irq_entry [*8])
        else $error("Vector loaded early.");

    a_entry_state: assert property (core_irq_entry |-> !gie_q && !$past(core_irq_entry)
        && core_vector_addr == mil_pkg::VECTOR)
        else $error("Entry without clearing the global enable.");

    a_gie_gates: assert property ($past(!gie_q) |-> !core_irq_req)
        else $error("Request with global enable clear.");

    a_req_cause: assert property (core_irq_req |-> $past(pending))
        else $error("Request with no enabled flag.");

    a_return_from_irq_instr_gie: assert property (core_return_from_irq_instr && !take |=> gie_q)
        else $error("Return did not set global enable.");

    a_clr_blocks: assert property (gie_clr_wr |=> !core_irq_entry [*4])
        else $error("Entry right after global enable clear.");

    a_timer_flag: assert property (evt.tmr_evt |=> tmr_flag_q)
        else $error("Timer event lost.");

    a_port_flag: assert property (evt.port_evt |=> port_flag_q)
        else $error("Port change event lost.");

    a_pin_window: assert property (
        $rose(pin_flag_q) && !$past(wr_intctl) |-> $past(pin_window))
        else $error("Pin flag set outside Q4 or Q1.");

    a_pin_set: assert property (evt.pin_evt |-> ##[1:4] pin_flag_q)
        else $error("Pin edge did not set its flag.");

    a_sleep_wake: assert property (core_sleep ##1 (pending && !core_sleep) |=> core_wake)
        else $error("No wake with enabled pending flag.");

endmodule

//--- mil_core_model.sv
// Behavioural core model that serves each interrupt entry and then returns.
`timescale 1ns/1ps
module mil_core_model #(
    parameter int SVC = 40
) (
    input  wire logic pclk,      // System clock.
    input  wire logic presetn,   // Asynchronous reset, active low.
    input  wire logic irq_entry, // Entry pulse from the block.
    output logic      return_from_irq_instr     // Return from interrupt, one cycle.
);
    int cnt_q;
    // Runs the service routine for SVC cycles, giving the bench time to clear flags first.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 0;
            return_from_irq_instr <= 1'b0;
        end else begin
            return_from_irq_instr <= (cnt_q == 1);
            cnt_q  <= irq_entry ? SVC : (cnt_q > 0 ? cnt_q - 1 : 0);
        end
    end
endmodule

//--- tb.sv
// Self-checking bench for the interrupt logic top.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
    logic        pclk, pready, pslverr, return_from_irq_instr, req, entry, err, nop, slept, wake;
    logic        prd = 1'b0, slp = 1'b0;
    logic [1:0]  ph;
    logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pin = 1'b0;
    logic [7:0]  paddr = 8'h00, tmr = 8'h00;
    logic [3:0]  port = 4'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [12:0] vec;
    int          fail_count = 0, checks_done = 0, cyc = 0, n;

    mil_top i_mil_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_irq_pin(pin), .port_two_hi(port), .timer_count(tmr),
        .core_port_read(prd), .core_return_from_irq_instr(return_from_irq_instr), .core_sleep(slp), .core_irq_req(req),
        .core_irq_entry(entry), .core_vector_addr(vec), .core_nop(nop), .core_asleep(slept),
        .core_wake(wake), .core_phase(ph));
    mil_core_model i_mil_core_model (.pclk(pclk), .presetn(presetn), .irq_entry(entry),
        .return_from_irq_instr(return_from_irq_instr));

    // ==========================================================
    // Clock, timeout and closing report.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ==========================================================
    // One APB transfer; holds the request until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Waits a bounded time for the entry pulse, counting cycles in n.
    task automatic wait_entry();
        n = 0;
        while (entry !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
    endtask

    // ==========================================================
    // Scenarios.
    task automatic t_reset();
        apb(0, mil_pkg::OFF_INTCTL, 0);
        `CHK("intctl", 32'h0, rdata)
        apb(0, mil_pkg::OFF_OPTION, 0);
        `CHK("option", {24'h0, mil_pkg::OPTION_RST}, rdata)
        apb(0, 8'h0c, 0);
        `CHK("slverr", 1'b1, err)
        $display("reset test done");
    endtask
    task automatic t_pin();
        apb(1, mil_pkg::OFF_OPTION, 0);
        apb(1, mil_pkg::OFF_INTCTL, 32'h80);
        pin <= 1'b1;
        repeat (12) @(posedge pclk);
        apb(0, mil_pkg::OFF_INTCTL, 0);
        `CHK("rise ignored", 32'h80, rdata)
        pin <= 1'b0;
        repeat (12) @(posedge pclk);
        `CHK("req masked", 1'b0, req)
        apb(0, mil_pkg::OFF_INTCTL, 0);
        `CHK("pin flag", 32'h82, rdata)
        apb(1, mil_pkg::OFF_INTCTL, 32'h10);
        apb(1, mil_pkg::OFF_OPTION, 32'h40);
        apb(1, mil_pkg::OFF_INTCTL, 32'h90);
        pin <= 1'b1;
        wait_entry();
        `CHK("latency", 1'b1, n <= 20)
        `CHK("vector", mil_pkg::VECTOR, vec)
        apb(0, mil_pkg::OFF_INTCTL, 0);
        `CHK("gie cleared", 32'h12, rdata)
        apb(1, mil_pkg::OFF_INTCTL, 32'h10);
        repeat (50) @(posedge pclk);
        apb(0, mil_pkg::OFF_INTCTL, 0);
        `CHK("gie restored", 32'h90, rdata)
        $display("pin test done");
    endtask
    task automatic t_timer();
        apb(1, mil_pkg::OFF_INTCTL, 0);
        tmr <= mil_pkg::TMR_MAX;
        @(posedge pclk);
        tmr <= mil_pkg::TMR_ZERO;
        repeat (4) @(posedge pclk);
        apb(0, mil_pkg::OFF_INTCTL, 0);
        `CHK("timer flag", 32'h04, rdata)
        apb(1, mil_pkg::OFF_INTCTL, 32'ha4);
        wait_entry();
        `CHK("timer entry", 1'b1, entry)
        apb(1, mil_pkg::OFF_INTCTL, 32'h20);
        repeat (50) @(posedge pclk);
        $display("timer test done");
    endtask
    task automatic t_port();
        apb(1, mil_pkg::OFF_INTCTL, 0);
        port <= 4'h5;
        repeat (8) @(posedge pclk);
        apb(0, mil_pkg::OFF_INTCTL, 0);
        `CHK("port flag", 32'h01, rdata)
        $display("port test done");
    endtask
    // Sleep with an enabled pending flag, port read, phase and the dummy cycle after a clear.
    task automatic t_sleep();
        apb(1, mil_pkg::OFF_INTCTL, 32'h08);
        slp <= 1'b1;
        @(posedge pclk);
        slp <= 1'b0;
        @(posedge pclk);
        `CHK("asleep", 1'b1, slept)
        @(posedge pclk);
        `CHK("wake", 1'b1, wake)
        `CHK("no vector", 1'b0, req)
        prd <= 1'b1;
        @(posedge pclk);
        prd <= 1'b0;
        apb(1, mil_pkg::OFF_INTCTL, 32'h08);
        apb(0, mil_pkg::OFF_INTCTL, 0);
        `CHK("port read", 32'h08, rdata)
        n = ph;
        @(posedge pclk);
        `CHK("phase", 2'(n + 1), ph)
        apb(1, mil_pkg::OFF_INTCTL, 32'h88);
        apb(1, mil_pkg::OFF_INTCTL, 32'h08);
        n = 0;
        repeat (12) begin
            @(posedge pclk);
            n += nop;
        end
        `CHK("nop cycles", 4, n)
        $display("sleep test done");
    endtask

    // Main sequence.
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_pin();
        t_timer();
        t_port();
        t_sleep();
        tally_and_finish();
    end
endmodule
